// >>> logic/glrx_pkg.sv
// Constants and carrier types of the listener receive engine.
// Assumes one 250 MHz clock and a word-wide register port.
//
// Summary of operation
// - Poll enable byte is 0110, sense, line.
// - Sense level and three-bit line choice.
// - String stops on length, terminator, or EOI.
// - String drops carriage returns and terminator.
// - Report count of stored bytes only.
// - Status bit 3 flags inter-byte timeout.
// - Status bit 2 flags destination overflow.
// - Status bit 1 flags start while unlistened.
// - Four terminators, reset LF CR comma semicolon.
// - Simple string receive uses terminator zero.
// - Array selector bit 2 enables terminator match.
// - Selector bits 1-0 pick the terminator.
// - Simple array receive ignores terminators, ends on EOI or count.
// - Array bytes pack low byte first.
// - Array bytes may leave by DMA.
// - Array byte count limited to 32767.
// - String count reaches 65535.
// - Array status bits 5, 3, 1.
`default_nettype none
package glrx_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TSEL = 8'h04;
  localparam logic [7:0] OFS_MAXLEN = 8'h08;
  localparam logic [7:0] OFS_TERMS = 8'h0C;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_RCVLEN = 8'h14;
  localparam logic [7:0] OFS_TMO = 8'h18;
  localparam logic [7:0] OFS_DATA = 8'h1C;
  localparam logic [7:0] OFS_PPE = 8'h20;
  // ==========================================================
  // Field positions
  localparam int CTRL_START = 0;
  localparam int CTRL_ARRAY = 1;
  localparam int CTRL_SIMPLE = 2;
  localparam int CTRL_DMA = 3;
  localparam int CTRL_BUSY = 7;
  localparam int TSEL_EN = 2;
  localparam int ST_NL = 1;
  localparam int ST_OVF = 2;
  localparam int ST_TMO = 3;
  localparam int ST_END = 5;
  localparam int DATA_VALID = 8;
  localparam logic [3:0] PPE_HEAD = 4'h6;
  // ==========================================================
  // Reset values and limits
  localparam logic [31:0] TERMS_RST = 32'h3B2C0D0A;
  localparam logic [7:0] CHAR_CR = 8'h0D;
  localparam logic [15:0] MAXLEN_RST = 16'hFFFF;
  localparam logic [15:0] ARRAY_MAX = 16'h7FFF;
  localparam logic [15:0] TMO_MS_RST = 16'h2710;
  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int MS_NS = 1000000;
  localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
  // ==========================================================
  // Types
  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_READY = 4'h2,
    S_STORE = 4'h4,
    S_RELEASE = 4'h8
  } glrx_state_t;
  typedef struct packed {
    logic valid;
    logic [14:0] wordAddr;
    logic [15:0] data;
    logic [1:0] byteEn;
  } glrx_wr_t;
endpackage : glrx_pkg
`default_nettype wire

// >>> logic/glrx_top.sv
// Listener receive engine: acceptor handshake, filtering, packing.
// Assumes bus pins arrive unsynchronised; DMA sink acks in-clock.
//
// Decided for this implementation: the register offsets and the address-and-strobe port.
`default_nettype none
module glrx_top import glrx_pkg::*; #(
  parameter int CycPerMs = CYC_PER_MS
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  // Bus pins, active low on the wire
  input wire logic [7:0] dioIn_n,
  input wire logic eoiIn_n,
  input wire logic davIn_n,
  output logic nrfdOut,
  output logic nrfdOe,
  output logic ndacOut,
  output logic ndacOe,
  // Listener addressed state from the bus front end
  input wire logic listenAddr,
  // DMA sink
  output glrx_wr_t dmaWr,
  input wire logic dmaAck,
  // Poll enable byte for transmission
  output logic [7:0] ppeByte
);
  // ==========================================================
  // Synchronisers
  logic [10:0] sync1, sync2;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {listenAddr, ~davIn_n, ~eoiIn_n, ~dioIn_n};
      sync2 <= sync1;
    end
  end
  logic isListener, davAct, eoiAct;
  logic [7:0] dioByte;
  assign {isListener, davAct, eoiAct, dioByte} = sync2;

  // ==========================================================
  // Registers
  logic arrayMode_r, simple_r, dmaEn_r;
  logic [7:0] termSel_r, ppeCfg_r, data_r;
  logic [15:0] maxLen_r, rcvLen_r, tmoMs_r;
  logic [31:0] terms_r;
  logic nlFlag_r, ovfFlag_r, tmoFlag_r, endFlag_r;
  logic outValid_r;
  logic startReq;
  glrx_state_t state_r;
  assign startReq = regWr && regAddr == OFS_CTRL && regWrData[CTRL_START];

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      arrayMode_r <= 1'b0;
      simple_r <= 1'b0;
      dmaEn_r <= 1'b0;
      termSel_r <= 8'h00;
      maxLen_r <= MAXLEN_RST;
      terms_r <= TERMS_RST;
      tmoMs_r <= TMO_MS_RST;
      ppeCfg_r <= 8'h00;
    end else if (regWr && state_r == S_IDLE) begin
      case (regAddr)
        OFS_CTRL: begin
          arrayMode_r <= regWrData[CTRL_ARRAY];
          simple_r <= regWrData[CTRL_SIMPLE];
          dmaEn_r <= regWrData[CTRL_DMA];
        end
        OFS_TSEL: termSel_r <= regWrData[7:0];
        OFS_MAXLEN: maxLen_r <= regWrData[15:0];
        OFS_TERMS: terms_r <= regWrData;
        OFS_TMO: tmoMs_r <= regWrData[15:0];
        OFS_PPE: ppeCfg_r <= {4'h0, regWrData[3:0]};
        default: ;
      endcase
    end
  end

  // Fixed head, sense bit, then line select
  assign ppeByte = {PPE_HEAD, ppeCfg_r[3], ppeCfg_r[2:0]};

  // ==========================================================
  // Terminator selection and byte classification
  function automatic logic [7:0] pickTerm(input logic [31:0] t, input logic [1:0] i);
    pickTerm = t[8*i +: 8];
  endfunction : pickTerm

  logic [1:0] termIdx;
  logic charTermEn, isCr, hitTerm, discard, isLast, storeIt;
  logic [15:0] effMax, nextLen;
  logic sinkFree;
  always_comb begin
    termIdx = simple_r ? 2'd0 : termSel_r[1:0];
    charTermEn = arrayMode_r ? (!simple_r && termSel_r[TSEL_EN]) : 1'b1;
    effMax = arrayMode_r && maxLen_r > ARRAY_MAX ? ARRAY_MAX : maxLen_r;
    isCr = dioByte == CHAR_CR;
    hitTerm = charTermEn && dioByte == pickTerm(terms_r, termIdx);
    discard = !arrayMode_r && (isCr || hitTerm);
    storeIt = !discard;
    nextLen = rcvLen_r + 16'd1;
    isLast = eoiAct || hitTerm || (storeIt && nextLen >= effMax);
    sinkFree = !outValid_r;
  end

  // ==========================================================
  // Inter-byte timeout
  logic [31:0] divCnt_r;
  logic [15:0] msCnt_r;
  logic msTick, tmoHit;
  assign msTick = divCnt_r == 32'(CycPerMs - 1);
  assign tmoHit = tmoMs_r != 16'h0000 && msCnt_r >= tmoMs_r;
  always_ff @(posedge sys_clk) begin
    if (!rst_n || state_r != S_READY) begin
      divCnt_r <= '0;
      msCnt_r <= '0;
    end else if (msTick) begin
      divCnt_r <= '0;
      msCnt_r <= msCnt_r + 16'd1;
    end else begin
      divCnt_r <= divCnt_r + 32'd1;
    end
  end

  // ==========================================================
  // Acceptor handshake and transfer sequence
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_r <= S_IDLE;
    end else begin
      case (state_r)
        S_IDLE: begin
          if (startReq && isListener && effMax != 16'h0000) begin
            state_r <= S_READY;
          end
        end
        S_READY: begin
          if (tmoHit) begin
            state_r <= S_IDLE;
          end else if (davAct) begin
            state_r <= S_STORE;
          end
        end
        S_STORE: begin
          if (discard || sinkFree) begin
            state_r <= S_RELEASE;
          end
        end
        S_RELEASE: begin
          if (!davAct) begin
            state_r <= endFlag_r || ovfFlag_r || rcvLen_r >= effMax ? S_IDLE : S_READY;
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // Ready only while waiting; accepted only after the byte is handled
  assign nrfdOut = 1'b0;
  assign ndacOut = 1'b0;
  assign nrfdOe = state_r != S_READY;
  assign ndacOe = state_r != S_RELEASE;

  // ==========================================================
  // Count and status
  logic accept;
  assign accept = state_r == S_STORE && (discard || sinkFree);
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rcvLen_r <= '0;
      nlFlag_r <= 1'b0;
      ovfFlag_r <= 1'b0;
      tmoFlag_r <= 1'b0;
      endFlag_r <= 1'b0;
    end else if (startReq && state_r == S_IDLE) begin
      rcvLen_r <= '0;
      nlFlag_r <= !isListener;
      ovfFlag_r <= 1'b0;
      tmoFlag_r <= 1'b0;
      endFlag_r <= 1'b0;
    end else if (state_r == S_READY && tmoHit) begin
      tmoFlag_r <= 1'b1;
    end else if (accept) begin
      if (storeIt) begin
        rcvLen_r <= nextLen;
      end
      if (eoiAct || hitTerm) begin
        endFlag_r <= 1'b1;
      end else if (storeIt && nextLen >= effMax && !arrayMode_r) begin
        ovfFlag_r <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Output slot: drained by a data read or by DMA
  // One slot keeps the handshake stalled rather than losing bytes.
  logic dataRead;
  assign dataRead = regRd && regAddr == OFS_DATA && !dmaEn_r;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      outValid_r <= 1'b0;
      data_r <= 8'h00;
    end else if (accept && storeIt) begin
      outValid_r <= 1'b1;
      data_r <= dioByte;
    end else if (dataRead || (dmaEn_r && dmaAck)) begin
      outValid_r <= 1'b0;
    end
  end

  logic [15:0] slotLen;
  assign slotLen = rcvLen_r - 16'd1;
  always_comb begin
    dmaWr.valid = outValid_r && dmaEn_r;
    dmaWr.wordAddr = slotLen[15:1];
    dmaWr.data = slotLen[0] ? {data_r, 8'h00} : {8'h00, data_r};
    dmaWr.byteEn = slotLen[0] ? 2'b10 : 2'b01;
  end

  // ==========================================================
  // Read port
  logic [7:0] statByte;
  always_comb begin
    statByte = 8'h00;
    statByte[ST_NL] = nlFlag_r;
    statByte[ST_TMO] = tmoFlag_r;
    if (arrayMode_r) begin
      statByte[ST_END] = endFlag_r;
    end else begin
      statByte[ST_OVF] = ovfFlag_r;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      regRdData <= '0;
    end else if (regRd) begin
      case (regAddr)
        OFS_CTRL: regRdData <= {24'h0, state_r != S_IDLE, 3'h0, dmaEn_r, simple_r,
                                arrayMode_r, 1'b0};
        OFS_TSEL: regRdData <= {24'h0, termSel_r};
        OFS_MAXLEN: regRdData <= {16'h0, maxLen_r};
        OFS_TERMS: regRdData <= terms_r;
        OFS_STAT: regRdData <= {24'h0, statByte};
        OFS_RCVLEN: regRdData <= {16'h0, rcvLen_r};
        OFS_TMO: regRdData <= {16'h0, tmoMs_r};
        OFS_DATA: regRdData <= {23'h0, outValid_r, data_r};
        OFS_PPE: regRdData <= {24'h0, ppeByte};
        default: regRdData <= '0;
      endcase
    end else begin
      regRdData <= '0;
    end
  end

  // ==========================================================
  // Checks
  sequence s_byteTaken;
    state_r == S_READY && davAct && !tmoHit;
  endsequence
  sequence s_byteHeld;
    state_r == S_STORE && nrfdOe && ndacOe;
  endsequence
  property p_handshake;
    @(posedge sys_clk) disable iff (!rst_n) s_byteTaken |=> s_byteHeld;
  endproperty
  a_handshake: assert property (p_handshake) else $error("byte not held");
  property p_ppeHead;
    @(posedge sys_clk) disable iff (!rst_n)
      regWr && regAddr == OFS_PPE && state_r == S_IDLE |=>
      ppeByte == {4'h6, $past(regWrData[3:0])};
  endproperty
  a_ppeHead: assert property (p_ppeHead) else $error("poll head wrong");
  property p_notListen;
    @(posedge sys_clk) disable iff (!rst_n)
      state_r == S_IDLE && startReq && !isListener |=> nlFlag_r && state_r == S_IDLE;
  endproperty
  a_notListen: assert property (p_notListen) else $error("nl missing");
  property p_crDropped;
    @(posedge sys_clk) disable iff (!rst_n)
      accept && !arrayMode_r && isCr |=> $stable(rcvLen_r);
  endproperty
  a_crDropped: assert property (p_crDropped) else $error("cr stored");
  property p_countUp;
    @(posedge sys_clk) disable iff (!rst_n)
      accept && storeIt |=> rcvLen_r == $past(rcvLen_r) + 16'd1 && outValid_r;
  endproperty
  a_countUp: assert property (p_countUp) else $error("count wrong");
  property p_timeout;
    @(posedge sys_clk) disable iff (!rst_n)
      state_r == S_READY && tmoHit |=> tmoFlag_r && state_r == S_IDLE;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout lost");
  sequence s_endTaken;
    accept && (eoiAct || hitTerm);
  endsequence
  property p_eoiEnds;
    @(posedge sys_clk) disable iff (!rst_n) s_endTaken |=> endFlag_r && state_r == S_RELEASE;
  endproperty
  a_eoiEnds: assert property (p_eoiEnds) else $error("eoi ignored");
  property p_lastStops;
    @(posedge sys_clk) disable iff (!rst_n)
      accept && isLast |=> endFlag_r || ovfFlag_r || rcvLen_r >= effMax;
  endproperty
  a_lastStops: assert property (p_lastStops) else $error("no stop");
  property p_endIdle;
    @(posedge sys_clk) disable iff (!rst_n)
      state_r == S_RELEASE && !davAct && (endFlag_r || ovfFlag_r) |=> state_r == S_IDLE;
  endproperty
  a_endIdle: assert property (p_endIdle) else $error("no idle after end");
  property p_arrayCap;
    @(posedge sys_clk) disable iff (!rst_n)
      arrayMode_r && state_r != S_IDLE |-> rcvLen_r <= 16'h7FFF;
  endproperty
  a_arrayCap: assert property (p_arrayCap) else $error("array cap");
  property p_dmaOnly;
    @(posedge sys_clk) disable iff (!rst_n)
      dmaWr.valid && !dmaAck && !regWr |=> dmaWr.valid && $stable(dmaWr.data) &&
      $stable(dmaWr.wordAddr);
  endproperty
  a_dmaOnly: assert property (p_dmaOnly) else $error("stray dma");
endmodule : glrx_top
`default_nettype wire

// >>> verif/glrx_bench.sv
// Self-checking bench of the listener receive engine.
// Assumes a talker model on the bus pins and a stalling DMA sink.
`default_nettype none
module glrx_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import glrx_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [31:0] regRdData;
  logic [7:0] dioIn_n;
  logic eoiIn_n, davIn_n, nrfdOe, ndacOe, hung;
  logic listenAddr = 1'b1;
  glrx_wr_t dmaWr;
  logic dmaAck = 1'b0;
  logic stall = 1'b0;
  logic [7:0] ppeByte;
  logic [7:0] got[$];
  logic [7:0] none[$];
  logic [15:0] words[8];
  logic [31:0] d;
  int fail_count = 0;
  int n_tests = 0;
  always #2 sys_clk = ~sys_clk;
  // Short millisecond so the timeout case stays brief
  glrx_top #(.CycPerMs(10)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .dioIn_n(dioIn_n), .eoiIn_n(eoiIn_n), .davIn_n(davIn_n), .nrfdOut(), .nrfdOe(nrfdOe),
    .ndacOut(), .ndacOe(ndacOe), .listenAddr(listenAddr), .dmaWr(dmaWr), .dmaAck(dmaAck),
    .ppeByte(ppeByte));
  glrx_talker tlk (.sys_clk(sys_clk), .nrfdOe(nrfdOe), .ndacOe(ndacOe), .dioIn_n(dioIn_n),
    .eoiIn_n(eoiIn_n), .davIn_n(davIn_n), .hung(hung));
  // ==========================================================
  // DMA sink, accepting every other cycle to stall the engine
  always @(posedge sys_clk) begin
    stall <= ~stall;
    dmaAck <= dmaWr.valid && stall && !dmaAck;
    // Lanes merge per word address, as a memory would hold them
    if (dmaWr.valid && dmaAck) begin
      if (dmaWr.byteEn[0]) words[dmaWr.wordAddr[2:0]][7:0] <= dmaWr.data[7:0];
      if (dmaWr.byteEn[1]) words[dmaWr.wordAddr[2:0]][15:8] <= dmaWr.data[15:8];
    end
  end
  // ==========================================================
  // Access tasks
  task automatic finish_test();
    if (fail_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= v;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    @(negedge sys_clk);
    v = regRdData;
  endtask : rd
  // One receive: start, feed bytes, drain the data slot, wait for idle
  task automatic rx(input logic [31:0] ctrl, input logic [7:0] tsel, input logic [15:0] len,
                    input logic [7:0] q[$], input logic eoiLast);
    logic [31:0] v;
    int k;
    got.delete();
    foreach (words[i]) words[i] = 16'h0000;
    wr(OFS_TSEL, {24'h0, tsel});
    wr(OFS_MAXLEN, {16'h0, len});
    wr(OFS_CTRL, ctrl | 32'h1);
    fork
      foreach (q[i]) tlk.send(q[i], eoiLast && i == q.size() - 1, i % 3);
      for (k = 0; k < 3000; k++) begin
        rd(OFS_DATA, v);
        if (v[DATA_VALID] === 1'b1 && !ctrl[CTRL_DMA]) got.push_back(v[7:0]);
        rd(OFS_CTRL, v);
        if (v[CTRL_BUSY] === 1'b0) break;
      end
    join
    rd(OFS_DATA, v);
    if (v[DATA_VALID] === 1'b1 && !ctrl[CTRL_DMA]) got.push_back(v[7:0]);
    if (k == 3000) begin
      fail_count++;
      finish_test();
    end
  endtask : rx
  task automatic fin(input logic [31:0] st, input logic [31:0] n);
    rd(OFS_STAT, d);
    chk(d, st);
    rd(OFS_RCVLEN, d);
    chk(d, n);
  endtask : fin
  // ==========================================================
  // Scenarios
  initial begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    chk({24'h0, ppeByte}, 32'h60);
    rd(OFS_MAXLEN, d);
    chk(d, 32'h0000FFFF);
    rd(OFS_TERMS, d);
    chk(d, 32'h3B2C0D0A);
    rd(OFS_TMO, d);
    chk(d, 32'h00002710);
    rd(8'hFC, d);
    chk(d, 32'h0);
    wr(OFS_PPE, 32'h0000000B);
    rd(OFS_PPE, d);
    chk(d, 32'h6B);
    wr(OFS_PPE, 32'h00000005);
    // Let the write land before looking
    @(negedge sys_clk);
    chk({24'h0, ppeByte}, 32'h65);
    rx(32'h0, 8'h02, 16'h10, {8'h41, 8'h0D, 8'h42, 8'h2C}, 1'b0);
    fin(32'h0, 32'h2);
    chk({16'h0, got[0], got[1]}, 32'h4142);
    rx(32'h0, 8'h02, 16'h2, {8'h58, 8'h59}, 1'b0);
    fin(32'h4, 32'h2);
    rx(32'h0, 8'h02, 16'h10, {8'h31, 8'h32}, 1'b1);
    fin(32'h0, 32'h2);
    rx(32'h4, 8'h03, 16'h10, {8'h3B, 8'h0A}, 1'b0);
    fin(32'h0, 32'h1);
    chk({24'h0, got[0]}, 32'h3B);
    rx(32'hA, 8'h06, 16'h10, {8'h01, 8'h02, 8'h03, 8'h2C}, 1'b0);
    fin(32'h20, 32'h4);
    chk({words[0], words[1]}, 32'h02012C03);
    // Enable bit clear, upper bits set: comma must pass through
    rx(32'hA, 8'hFA, 16'h10, {8'h2C, 8'h55}, 1'b1);
    fin(32'h20, 32'h2);
    chk({16'h0, words[0]}, 32'h552C);
    rx(32'hE, 8'h06, 16'h10, {8'h2C, 8'h66}, 1'b1);
    fin(32'h20, 32'h2);
    chk({16'h0, words[0]}, 32'h662C);
    // Array without DMA: CR and LF kept, count alone ends it
    rx(32'h2, 8'h00, 16'h3, {8'h0D, 8'h0A, 8'h77}, 1'b0);
    fin(32'h0, 32'h3);
    chk({8'h0, got[0], got[1], got[2]}, 32'h000D0A77);
    @(posedge sys_clk);
    listenAddr <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rx(32'h0, 8'h02, 16'h10, none, 1'b0);
    fin(32'h2, 32'h0);
    @(posedge sys_clk);
    listenAddr <= 1'b1;
    repeat (4) @(posedge sys_clk);
    wr(OFS_TMO, 32'h1);
    rx(32'h0, 8'h02, 16'h10, none, 1'b0);
    fin(32'h8, 32'h0);
    chk({31'h0, hung}, 32'h0);
    finish_test();
  end
endmodule : glrx_bench
`default_nettype wire

// >>> verif/glrx_talker.sv
// Talker on the far side of the listener receive engine.
// Assumes the open-drain acceptor lines are seen through their enables.
`default_nettype none
module glrx_talker (
  // Clock
  input wire logic sys_clk,
  // Acceptor lines, high while pulled low
  input wire logic nrfdOe,
  input wire logic ndacOe,
  // Source lines, active low on the wire
  output logic [7:0] dioIn_n,
  output logic eoiIn_n,
  output logic davIn_n,
  // Set when the acceptor never answered
  output logic hung
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    dioIn_n = 8'hFF;
    eoiIn_n = 1'b1;
    davIn_n = 1'b1;
    hung = 1'b0;
  end
  // ==========================================================
  // Source handshake
  task automatic waitFree(input logic useNdac);
    int n = 0;
    while (((useNdac ? ndacOe : nrfdOe) !== 1'b0) && n < 4000) begin
      @(posedge sys_clk);
      n++;
    end
    if (n == 4000) hung <= 1'b1;
  endtask : waitFree
  task automatic send(input logic [7:0] b, input logic e, input int slow);
    repeat (slow) @(posedge sys_clk);
    waitFree(1'b0);
    dioIn_n <= ~b;
    eoiIn_n <= ~e;
    // Data settle a cycle ahead of the valid strobe
    @(posedge sys_clk);
    davIn_n <= 1'b0;
    waitFree(1'b1);
    davIn_n <= 1'b1;
    // Released lines float to the bus pull-up
    dioIn_n <= 8'hFF;
    eoiIn_n <= 1'b1;
  endtask : send
endmodule : glrx_talker
`default_nettype wire
